//--- rtl/jbt_map.vh
// Constants of the boundary-scan test port: state codes, instruction codes, widths.
// Assumes inclusion by jbt_tap.v and jbt_shreg.v only.
`ifndef JBT_MAP_VH
`define JBT_MAP_VH
`define JBT_ST_TLR 4'h0
`define JBT_ST_RTI 4'h1
`define JBT_ST_SEL_DR 4'h2
`define JBT_ST_CAP_DR 4'h3
`define JBT_ST_SH_DR 4'h4
`define JBT_ST_EX1_DR 4'h5
`define JBT_ST_PAU_DR 4'h6
`define JBT_ST_EX2_DR 4'h7
`define JBT_ST_UPD_DR 4'h8
`define JBT_ST_SEL_IR 4'h9
`define JBT_ST_CAP_IR 4'ha
`define JBT_ST_SH_IR 4'hb
`define JBT_ST_EX1_IR 4'hc
`define JBT_ST_PAU_IR 4'hd
`define JBT_ST_EX2_IR 4'he
`define JBT_ST_UPD_IR 4'hf
`define JBT_IR_W 3
`define JBT_IR_EXTEST 3'h0
`define JBT_IR_IDCODE 3'h1
`define JBT_IR_SAMPLE_Z 3'h2
`define JBT_IR_PRIVATE 3'h3
`define JBT_IR_SAMPLE 3'h4
`define JBT_IR_CAPTURE 3'h1
`define JBT_ID_W 32
`define JBT_BSR_W 8
`define JBT_TLR_ONES 3'h5
`endif

//--- rtl/jbt_shreg.v
// Generic capture/shift register of the test port.
// Assumes capture and shift strobes are single-cycle, taken at a test clock rising edge.
`include "jbt_map.vh"
module jbt_shreg #(
  parameter W = 8
) (
  input wire clock,
  input wire rstn,
  input wire capture,
  input wire shift,
  input wire [W-1:0] cap_value,
  input wire sdi,
  output reg [W-1:0] value
);
  always @(posedge clock) begin
    if (!rstn) begin
      value <= {W{1'b0}};
    end else if (capture) begin
      value <= cap_value;
    end else if (shift) begin
      // LSB leaves first, new bit enters at MSB
      value <= {sdi, value[W-1:1]}; // [R03]
    end
  end
endmodule // jbt_shreg

//--- rtl/jbt_tap.v
// Test access port: state machine, instruction register, id, bypass, boundary register.
// Assumes tck, tms, tdi come from pins asynchronous to clock, and clock runs well above tck.
// Operation
// [R01] State changes only on test clock edges
// [R02] Mode select sampled at rising test clock
// [R03] Serial input captured at rising test clock
// [R04] Serial output updated at falling test clock
// [R05] One instruction register, several selectable data registers
// [R06] Only external test, sample-z take pins
// [R07] Unused port: clock low, inputs high
// [R08] Five ones on mode select reset logic
// [R09] Three-bit instruction, loads 001, applies at update
// [R10] Output driven, input sampled only in shift
// [R11] Decode 000 extest, 010 sample-z, 100 sample
// [R12] Standard sixteen-state transition graph
`include "jbt_map.vh"
module jbt_tap #(
  parameter [31:0] ID_CODE = 32'h0000_0001 // Arbitrary identification value
) (
  input wire clock,
  input wire rstn,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe,
  input wire [7:0] pin_sense,
  output reg [7:0] pin_drive,
  output wire pin_override,
  output wire out_hiz,
  output wire odt_off,
  output reg [2:0] instr,
  output reg [3:0] tap_state
);
  reg [2:0] tck_s;
  reg [1:0] tms_s;
  reg [1:0] tdi_s;
  reg [2:0] ir_shift;
  reg bypass;
  reg [3:0] next_state;
  wire tck_rise;
  wire tck_fall;
  wire [31:0] id_value;
  wire [7:0] bsr_value;
  reg sel_bit;
  reg [2:0] ones_run;
  reg [7:0] sense_s0;
  reg [7:0] sense_s1;

  // Two-stage synchronisers; stage two and three feed edge detection
  always @(posedge clock) begin
    if (!rstn) begin
      tck_s <= 3'h0;
      tms_s <= 2'h3;
      tdi_s <= 2'h3;
    end else begin
      tck_s <= {tck_s[1:0], tck};
      tms_s <= {tms_s[0], tms};
      tdi_s <= {tdi_s[0], tdi};
    end
  end
  assign tck_rise = tck_s[1] & ~tck_s[2]; // [R02]
  assign tck_fall = ~tck_s[1] & tck_s[2]; // [R04]

  // Pin levels wander freely; two stages keep the boundary capture clean
  always @(posedge clock) begin
    if (!rstn) begin
      sense_s0 <= 8'h00;
      sense_s1 <= 8'h00;
    end else begin
      sense_s0 <= pin_sense;
      sense_s1 <= sense_s0;
    end
  end

  // Consecutive rises with mode select high; saturates at the reset count
  always @(posedge clock) begin
    if (!rstn) begin
      ones_run <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s[1]) begin
        ones_run <= 3'h0;
      end else if (ones_run != `JBT_TLR_ONES) begin
        ones_run <= ones_run + 3'h1; // [R08]
      end
    end
  end

  function is_shift_dr;
    input [3:0] st;
    is_shift_dr = (st == `JBT_ST_SH_DR);
  endfunction

  function is_shift_ir;
    input [3:0] st;
    is_shift_ir = (st == `JBT_ST_SH_IR);
  endfunction

  function is_dr_bsr;
    input [2:0] ir;
    is_dr_bsr = (ir == `JBT_IR_EXTEST) | (ir == `JBT_IR_SAMPLE_Z) | (ir == `JBT_IR_SAMPLE);
  endfunction

  always @* begin
    next_state = tap_state;
    case (tap_state) // [R12]
      `JBT_ST_TLR: next_state = tms_s[1] ? `JBT_ST_TLR : `JBT_ST_RTI;
      `JBT_ST_RTI: next_state = tms_s[1] ? `JBT_ST_SEL_DR : `JBT_ST_RTI;
      `JBT_ST_SEL_DR: next_state = tms_s[1] ? `JBT_ST_SEL_IR : `JBT_ST_CAP_DR;
      `JBT_ST_CAP_DR: next_state = tms_s[1] ? `JBT_ST_EX1_DR : `JBT_ST_SH_DR;
      `JBT_ST_SH_DR: next_state = tms_s[1] ? `JBT_ST_EX1_DR : `JBT_ST_SH_DR;
      `JBT_ST_EX1_DR: next_state = tms_s[1] ? `JBT_ST_UPD_DR : `JBT_ST_PAU_DR;
      `JBT_ST_PAU_DR: next_state = tms_s[1] ? `JBT_ST_EX2_DR : `JBT_ST_PAU_DR;
      `JBT_ST_EX2_DR: next_state = tms_s[1] ? `JBT_ST_UPD_DR : `JBT_ST_SH_DR;
      `JBT_ST_UPD_DR: next_state = tms_s[1] ? `JBT_ST_SEL_DR : `JBT_ST_RTI;
      // Five ones from any state other than reset reach reset through this branch
      `JBT_ST_SEL_IR: next_state = tms_s[1] ? `JBT_ST_TLR : `JBT_ST_CAP_IR; // [R08]
      `JBT_ST_CAP_IR: next_state = tms_s[1] ? `JBT_ST_EX1_IR : `JBT_ST_SH_IR;
      `JBT_ST_SH_IR: next_state = tms_s[1] ? `JBT_ST_EX1_IR : `JBT_ST_SH_IR;
      `JBT_ST_EX1_IR: next_state = tms_s[1] ? `JBT_ST_UPD_IR : `JBT_ST_PAU_IR;
      `JBT_ST_PAU_IR: next_state = tms_s[1] ? `JBT_ST_EX2_IR : `JBT_ST_PAU_IR;
      `JBT_ST_EX2_IR: next_state = tms_s[1] ? `JBT_ST_UPD_IR : `JBT_ST_SH_IR;
      `JBT_ST_UPD_IR: next_state = tms_s[1] ? `JBT_ST_SEL_DR : `JBT_ST_RTI;
      default: next_state = `JBT_ST_TLR;
    endcase
    // Backstop: five mode-select ones force reset even from a corrupted state code
    if (tms_s[1] && (ones_run == `JBT_TLR_ONES - 3'h1)) begin // [R08]
      next_state = `JBT_ST_TLR;
    end
  end

  // State, instruction shift and instruction latch
  always @(posedge clock) begin
    if (!rstn) begin
      tap_state <= `JBT_ST_TLR; // [R08]
      ir_shift <= `JBT_IR_IDCODE;
      instr <= `JBT_IR_IDCODE; // [R09]
      bypass <= 1'b0;
    end else if (tck_rise) begin
      tap_state <= next_state; // [R01]
      // Load on entry so the id instruction holds for the whole reset stay
      if (next_state == `JBT_ST_TLR) begin
        instr <= `JBT_IR_IDCODE; // [R09]
        ir_shift <= `JBT_IR_IDCODE;
      end else if (tap_state == `JBT_ST_CAP_IR) begin
        ir_shift <= `JBT_IR_CAPTURE; // [R09]
      end else if (is_shift_ir(tap_state)) begin
        ir_shift <= {tdi_s[1], ir_shift[2:1]}; // [R03]
      end else if (next_state == `JBT_ST_UPD_IR) begin
        // New instruction acts from the first cycle of update, never earlier
        instr <= ir_shift; // [R09]
      end
      // Bypass captures zero, as the standard graph expects
      if (tap_state == `JBT_ST_CAP_DR) begin
        bypass <= 1'b0;
      end else if (tap_state == `JBT_ST_SH_DR) begin
        bypass <= tdi_s[1];
      end
    end
  end

  wire in_cap_dr = tck_rise & (tap_state == `JBT_ST_CAP_DR);
  wire in_sh_dr = tck_rise & is_shift_dr(tap_state); // [R10]

  jbt_shreg #(.W(`JBT_ID_W)) u_id (
    .clock(clock),
    .rstn(rstn),
    .capture(in_cap_dr & (instr == `JBT_IR_IDCODE)),
    .shift(in_sh_dr & (instr == `JBT_IR_IDCODE)),
    .cap_value(ID_CODE),
    .sdi(tdi_s[1]),
    .value(id_value)
  );

  // Width is a chosen figure; a real pin ring is far longer
  jbt_shreg #(.W(`JBT_BSR_W)) u_bsr (
    .clock(clock),
    .rstn(rstn),
    .capture(in_cap_dr & is_dr_bsr(instr)),
    .shift(in_sh_dr & is_dr_bsr(instr)),
    .cap_value(sense_s1),
    .sdi(tdi_s[1]),
    .value(bsr_value)
  );

  // Boundary outputs only change at update, so pins never ripple while shifting
  always @(posedge clock) begin
    if (!rstn) begin
      pin_drive <= 8'h00;
    end else if (tck_rise && tap_state == `JBT_ST_UPD_DR && instr == `JBT_IR_EXTEST) begin
      pin_drive <= bsr_value;
    end
  end
  assign pin_override = (instr == `JBT_IR_EXTEST); // [R06]
  assign out_hiz = (instr == `JBT_IR_SAMPLE_Z); // [R11]
  assign odt_off = (instr == `JBT_IR_EXTEST) | (instr == `JBT_IR_SAMPLE_Z); // [R11]

  // Register selected between tdi and tdo
  always @* begin
    // Private and unused codes fall through to the one-bit bypass
    sel_bit = bypass; // [R05]
    if (is_shift_ir(tap_state)) begin
      sel_bit = ir_shift[0];
    end else if (instr == `JBT_IR_IDCODE) begin
      sel_bit = id_value[0];
    end else if (is_dr_bsr(instr)) begin
      sel_bit = bsr_value[0];
    end
  end

  // Output settles within three clocks of the test clock fall, ahead of the controller's sample at the next rise
  always @(posedge clock) begin
    if (!rstn) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= sel_bit; // [R04]
      // Recomputed at every fall, so the enable drops at the fall after shift
      tdo_oe <= is_shift_ir(tap_state) | is_shift_dr(tap_state); // [R10]
    end
  end
  // Idle tck low and tms high keep the port parked in reset [R07]
endmodule // jbt_tap

//--- testbench/jbt_tap_assertions.sv
// Checker of the test port outputs.
// Assumes tck halves of at least 4 clocks.
module jbt_tap_assertions (
  input wire logic clock,
  input wire logic rstn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic pin_override,
  input wire logic out_hiz,
  input wire logic [7:0] pin_drive,
  input wire logic [2:0] instr,
  input wire logic [3:0] tap_state
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic tck_q;
  logic [2:0] ones;
  // Rises of tck seen with tms high
  always @(posedge clock) begin
    tck_q <= tck;
    if (!rstn || !tms) ones <= 3'h0;
    else if (tck && !tck_q && ones != 3'h7) ones <= ones + 3'h1;
  end
  AST_STATE: assert property (!tck [*4] |-> $stable(tap_state))
    else $error("state moved");
  AST_TDO: assert property (tck [*4] |-> $stable(tdo) && $stable(tdo_oe))
    else $error("tdo moved");
  AST_OE: assert property ($rose(tdo_oe) |-> tap_state == 4'h4 || tap_state == 4'hb)
    else $error("oe outside shift");
  AST_IR_TLR: assert property (tap_state == 4'h0 && $past(tap_state) == 4'h0 |-> instr == 3'h1)
    else $error("instr not 001");
  AST_IR_UPD: assert property ($changed(instr) |-> tap_state inside {4'h0, 4'hf})
    else $error("instr early");
  AST_DEC: assert property (pin_override == (instr == 3'h0) && out_hiz == (instr == 3'h2))
    else $error("bad decode");
  AST_DRV: assert property ($changed(pin_drive) |-> instr == 3'h0)
    else $error("pins taken");
  AST_FIVE: assert property (ones >= 3'h6 |-> tap_state == 4'h0)
    else $error("no reset state");
endmodule // jbt_tap_assertions

//--- testbench/jbt_ctl.sv
// Behavioural test controller driving the test port pins.
// Assumes a 100 ns clock; one tck period is 8 clocks.
module jbt_ctl (
  input wire logic clock,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // Mode and data set 300 ns before the rise, held at least 400 ns after it
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clock);
    #1 tms = m;
    tdi = d;
    repeat (3) @(posedge clock);
    #1 tck = 1'b1;
    o = tdo;
    repeat (4) @(posedge clock);
    #1 tck = 1'b0;
    tdi = 1'b1;
  endtask
endmodule // jbt_ctl

//--- testbench/tb_jbt_tap.sv
// Bench of the boundary-scan test port.
// Assumes jbt_ctl as controller and the checker bound below.
module tb_jbt_tap;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ID = 32'h5a5a_0f0f; // Arbitrary value
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] pin_sense = 8'h00;
  logic tck, tms, tdi, tdo, tdo_oe, pin_override, out_hiz, odt_off;
  logic [7:0] pin_drive;
  logic [2:0] instr;
  logic [3:0] tap_state;
  logic [31:0] d;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %0t %h %h", $time, a, e); end end
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  jbt_ctl ctl (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  jbt_tap #(.ID_CODE(ID)) dut (.clock(clock), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_sense(pin_sense), .pin_drive(pin_drive),
    .pin_override(pin_override), .out_hiz(out_hiz), .odt_off(odt_off), .instr(instr),
    .tap_state(tap_state));
  task automatic wrap_up();
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic go(input logic [7:0] m, input int n);
    logic o;
    for (int i = 0; i < n; i++) ctl.step(m[i], 1'b1, o);
  endtask
  task automatic scan(input int n, input logic [31:0] din);
    logic o;
    d = 32'h0;
    for (int i = 0; i < n; i++) begin
      ctl.step(i == n - 1, din[i], o);
      d[i] = o;
      `CHK(tdo_oe, 1'b1)
    end
    go(8'h01, 2);
  endtask
  task automatic t_reset();
    `CHK(instr, 3'h1)
    go(8'h00, 1);
    `CHK(tap_state, 4'h1)
  endtask
  task automatic t_id();
    go(8'h01, 3);
    scan(32, 32'hffff_ffff);
    `CHK(d, ID)
    `CHK(tdo_oe, 1'b0)
  endtask
  task automatic t_codes();
    logic [11:0] tab = {3'h4, 3'h3, 3'h2, 3'h0};
    logic [2:0] c;
    for (int i = 0; i < 4; i++) begin
      c = tab[i*3 +: 3];
      go(8'h03, 4);
      scan(3, {29'h0, c});
      `CHK(d[2:0], 3'h1)
      `CHK(instr, c)
      `CHK({pin_override, out_hiz, odt_off}, {c == 3'h0, c == 3'h2, c[0] == 1'b0 && c != 3'h4})
    end
    pin_sense = 8'ha5;
    go(8'h01, 3);
    scan(8, 32'h3c);
    `CHK(pin_drive, 8'h00)
  endtask
  task automatic t_extest();
    go(8'h03, 4);
    scan(3, 32'h0);
    go(8'h01, 3);
    scan(8, 32'h3c);
    `CHK(d[7:0], 8'ha5)
    `CHK(pin_drive, 8'h3c)
    go(8'h01, 3);
    go(8'h1f, 5);
    `CHK(tap_state, 4'h0)
    `CHK(instr, 3'h1)
    go(8'h01, 1);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_id();
    t_codes();
    t_extest();
    wrap_up();
  end
endmodule // tb_jbt_tap
bind jbt_tap jbt_tap_assertions chk (.clock(clock), .rstn(rstn), .tck(tck), .tms(tms),
  .tdo(tdo), .tdo_oe(tdo_oe), .pin_override(pin_override), .out_hiz(out_hiz),
  .pin_drive(pin_drive), .instr(instr), .tap_state(tap_state));
